// ===== pkg/memory_map_consts.svh
// address map constants, field positions and sizes for the memory map decoder
`ifndef MEMORY_MAP_CONSTS_SVH
`define MEMORY_MAP_CONSTS_SVH

// segment and page geometry
`define ADDR_W            24
`define SEG_HI            23
`define SEG_LO            16
`define PAGE_HI           15
`define PAGE_LO           14

// segment 0 windows (low 16 bits)
`define EXTLO_END         16'h7fff
`define STANDBY_RAM_BASE        16'h8000
`define STANDBY_RAM_END         16'h9fff
`define DATA_SRAM_BASE        16'ha000
`define DATA_SRAM_END         16'hdfff
`define EXTRA_PERIPH_REGS_BASE         16'he000
`define EXTRA_PERIPH_REGS_END          16'hefff
`define EXTENDED_FUNCTION_REGS_BASE         16'hf000
`define EXTENDED_FUNCTION_REGS_END          16'hf1ff
`define DUAL_PORT_RAM_RSV_END     16'hf5ff
`define DUAL_PORT_RAM_BASE        16'hf600
`define DUAL_PORT_RAM_END         16'hfdff
`define SFR_BASE          16'hfe00
`define DUAL_PORT_RAM_BIT_PAGE    8'hfd

// local peripheral bus windows
`define LBUS_A_BASE       24'h200000
`define LBUS_A_END        24'h205fff
`define LBUS_B_BASE       24'h208000
`define LBUS_B_END        24'h20bfff
`define LBUS_HOLE_END     24'h20ffff
`define EXTIO_BASE        24'h210000
`define EXTIO_END         24'h3fffff
`define EXTMEM_END        24'hbfffff

// program region
`define FLASH_BASE        24'hc00000
`define FLASH_END         24'hccffff
`define FLASH_RSV_END     24'hdfffff
`define PROGRAM_SRAM_BASE        24'he00000
`define PROGRAM_SRAM_END         24'he7ffff
`define FLASH_TIMED_PROGRAM_RAM_END        24'hefffff
`define TRAP_END          24'hfffeff
`define FLASH_CTRL_SECTOR 12'hc0f

// flash geometry
`define FLASH_MODULES     4
`define FLASH_SECTORS     256
`define FLASH_LINE_W      128
`define FLASH_CHK_W       8
`define PROG_BLOCK_LSB    7

// write protection and password
`define PROGRAM_SRAM_WP_W        6
`define PW_WORDS          4

`endif

// ===== pkg/memory_map_pkg.sv
// types shared by the memory map decoder
`include "memory_map_consts.svh"
package memory_map_pkg;

  typedef enum logic [3:0] {
    TGT_NONE, TGT_EXT, TGT_LBUS, TGT_FLASH, TGT_PROGRAM_SRAM, TGT_FLASH_TIMED_PROGRAM_RAM, TGT_DATA_SRAM,
    TGT_DUAL_PORT_RAM, TGT_STANDBY_RAM, TGT_SFR, TGT_EXTENDED_FUNCTION_REGS, TGT_EXTRA_PERIPH_REGS, TGT_IMB, TGT_TRAP
  } target_t;

  typedef enum logic {PW_LOCKED, PW_OPEN} pw_state_t;

  typedef struct packed {
    logic                          f_valid;
    target_t                       f_tgt;
    logic [`ADDR_W-1:0]            f_addr;
    logic                          f_sysbus;
    logic                          f_trap;
    logic                          d_valid;
    target_t                       d_tgt;
    logic                          d_we;
    logic [1:0]                    d_be;
    logic [`ADDR_W-1:0]            d_addr;
    logic [15:0]                   d_wdata;
    logic                          d_sysbus;
    logic                          d_trap;
    logic                          d_wblock;
    logic                          d_rdeny;
    logic                          d_ioorder;
    logic                          d_bitok;
    logic                          d_retry;
    logic [`FLASH_MODULES-1:0]     fl_en;
    logic [`FLASH_MODULES-1:0]     fl_from_data;
    logic [`ADDR_W-1:0]            gpr_addr;
    logic                          gpr_valid;
    pw_state_t                     pw_state;
    logic [1:0]                    pw_idx;
    logic [`FLASH_LINE_W-1:0]      ecc_data;
    logic                          ecc_valid;
    logic                          ecc_corr;
    logic                          ecc_uncorr;
  } dec_state_t;

endpackage : memory_map_pkg

// ===== design/memory_map_decoder.sv
// address decoder and router for code fetches and data accesses
`timescale 1ns/1ps
`default_nettype none
`include "memory_map_consts.svh"

module memory_map_decoder #(
  parameter bit HAS_EXT_BUS = 1'b1
) (
  // clock and reset
  input  wire logic                                   clk,
  input  wire logic                                   rst_n,
  // code fetch port
  input  wire logic                                   fetch_req,
  input  wire logic [`ADDR_W-1:0]                     fetch_addr,
  // data access port
  input  wire logic                                   data_req,
  input  wire logic                                   data_we,
  input  wire logic                                   data_word,
  input  wire logic [`ADDR_W-1:0]                     data_addr,
  input  wire logic [15:0]                            data_wdata,
  // register bank addressing
  input  wire logic                                   gpr_req,
  input  wire logic [`ADDR_W-1:0]                     gpr_base,
  input  wire logic [3:0]                             gpr_num,
  input  wire logic                                   gpr_byte,
  input  wire logic                                   gpr_high,
  // protection settings
  input  wire logic [`PROGRAM_SRAM_WP_W-1:0]                 program_sram_wp_kbytes,
  input  wire logic [`FLASH_SECTORS-1:0]              flash_sector_wp,
  input  wire logic                                   flash_read_prot,
  input  wire logic                                   pw_valid,
  input  wire logic [15:0]                            pw_word,
  input  wire logic [`PW_WORDS*16-1:0]                pw_key,
  input  wire logic                                   pw_relock,
  // flash read return
  input  wire logic                                   flash_rvalid,
  input  wire logic [`FLASH_LINE_W-1:0]               flash_rdata,
  input  wire logic [`FLASH_CHK_W-1:0]                flash_rcheck,
  // decoded fetch
  output logic                                        fetch_valid,
  output memory_map_pkg::target_t                     fetch_target,
  output logic [`ADDR_W-1:0]                          fetch_addr_out,
  output logic                                        fetch_via_sysbus,
  output logic                                        fetch_trap,
  // decoded data access
  output logic                                        acc_valid,
  output memory_map_pkg::target_t                     acc_target,
  output logic                                        acc_we,
  output logic [1:0]                                  acc_be,
  output logic [`ADDR_W-1:0]                          acc_addr,
  output logic [15:0]                                 acc_wdata,
  output logic                                        acc_via_sysbus,
  output logic                                        acc_trap,
  output logic                                        acc_write_blocked,
  output logic                                        acc_read_denied,
  output logic                                        acc_io_ordered,
  output logic                                        acc_bit_ok,
  output logic                                        acc_retry,
  // flash module read strobes
  output logic [`FLASH_MODULES-1:0]                   flash_rd_en,
  output logic [`FLASH_MODULES-1:0]                   flash_rd_for_data,
  // register bank location
  output logic                                        gpr_valid,
  output logic [`ADDR_W-1:0]                          gpr_addr,
  // flash protection state
  output logic                                        flash_unlocked,
  // corrected flash data
  output logic                                        ecc_valid,
  output logic [`FLASH_LINE_W-1:0]                    ecc_data,
  output logic                                        ecc_corrected,
  output logic                                        ecc_uncorrectable
);
  import memory_map_pkg::*;

  // ************************************************************
  // address decode
  // ************************************************************

  function automatic target_t resolve_reserved();
    return HAS_EXT_BUS ? TGT_EXT : TGT_TRAP;
  endfunction : resolve_reserved

  function automatic target_t decode(input logic [`ADDR_W-1:0] a);
    logic [15:0] lo;
    target_t     t;
    lo = a[15:0];
    t  = TGT_TRAP;
    if (a[`SEG_HI:`SEG_LO] == 8'h00) begin
      if (lo <= `EXTLO_END)          t = TGT_EXT;
      else if (lo <= `STANDBY_RAM_END)     t = TGT_STANDBY_RAM;
      else if (lo <= `DATA_SRAM_END)     t = TGT_DATA_SRAM;
      else if (lo <= `EXTRA_PERIPH_REGS_END)      t = TGT_EXTRA_PERIPH_REGS;
      else if (lo <= `EXTENDED_FUNCTION_REGS_END)      t = TGT_EXTENDED_FUNCTION_REGS;
      else if (lo <= `DUAL_PORT_RAM_RSV_END) t = resolve_reserved();
      else if (lo <= `DUAL_PORT_RAM_END)     t = TGT_DUAL_PORT_RAM;
      else                           t = TGT_SFR;
    end else if (a < `LBUS_A_BASE) begin
      t = TGT_EXT;
    end else if (a <= `LBUS_A_END) begin
      t = TGT_LBUS;
    end else if (a < `LBUS_B_BASE) begin
      t = resolve_reserved();
    end else if (a <= `LBUS_B_END) begin
      t = TGT_LBUS;
    end else if (a <= `LBUS_HOLE_END) begin
      t = resolve_reserved();
    end else if (a <= `EXTMEM_END) begin
      t = TGT_EXT;
    end else if (a <= `FLASH_END) begin
      t = TGT_FLASH;
    end else if (a <= `FLASH_RSV_END) begin
      t = resolve_reserved();
    end else if (a <= `PROGRAM_SRAM_END) begin
      t = TGT_PROGRAM_SRAM;
    end else if (a <= `FLASH_TIMED_PROGRAM_RAM_END) begin
      t = TGT_FLASH_TIMED_PROGRAM_RAM;
    end else if (a <= `TRAP_END) begin
      t = TGT_TRAP;
    end else begin
      t = TGT_IMB;
    end
    return t;
  endfunction : decode

  // program sram and flash timed program ram repeat every 32 Kbytes across their windows
  function automatic logic [`ADDR_W-1:0] fold(input target_t t,
                                              input logic [`ADDR_W-1:0] a);
    logic [`ADDR_W-1:0] r;
    r = a;
    if (t == TGT_PROGRAM_SRAM || t == TGT_FLASH_TIMED_PROGRAM_RAM)
      r = {a[`ADDR_W-1:19], 4'h0, a[14:0]};
    return r;
  endfunction : fold

  function automatic logic is_ctrl_sector(input logic [`ADDR_W-1:0] a);
    return a[`ADDR_W-1:12] == `FLASH_CTRL_SECTOR;
  endfunction : is_ctrl_sector

  function automatic logic is_code_mem(input target_t t);
    return t == TGT_FLASH || t == TGT_PROGRAM_SRAM || t == TGT_FLASH_TIMED_PROGRAM_RAM;
  endfunction : is_code_mem

  // ************************************************************
  // flash error correction
  // ************************************************************

  // single error correction: data bit i sits at the i-th non power of two position
  function automatic logic [`FLASH_CHK_W-1:0] ecc_syndrome(
      input logic [`FLASH_LINE_W-1:0] d, input logic [`FLASH_CHK_W-1:0] c);
    logic [7:0] s;
    logic [7:0] p;
    s = c;
    p = 8'h03;
    for (int i = 0; i < `FLASH_LINE_W; i++) begin
      if ((p & (p - 8'h01)) == 8'h00) p = p + 8'h01;
      if (d[i]) s = s ^ p;
      p = p + 8'h01;
    end
    return s;
  endfunction : ecc_syndrome

  function automatic logic [`FLASH_LINE_W:0] ecc_fix(
      input logic [`FLASH_LINE_W-1:0] d, input logic [`FLASH_CHK_W-1:0] s);
    logic [`FLASH_LINE_W-1:0] r;
    logic [7:0]               p;
    logic                     hit;
    r   = d;
    p   = 8'h03;
    hit = 1'b0;
    for (int i = 0; i < `FLASH_LINE_W; i++) begin
      if ((p & (p - 8'h01)) == 8'h00) p = p + 8'h01;
      if (p == s) begin
        r[i] = ~r[i];
        hit  = 1'b1;
      end
      p = p + 8'h01;
    end
    return {hit, r};
  endfunction : ecc_fix

  // ************************************************************
  // next state
  // ************************************************************

  dec_state_t st_r;
  dec_state_t st_nxt;

  always_comb begin
    target_t                  ft;
    target_t                  dt;
    logic [`ADDR_W-1:0]       da;
    logic [7:0]               gsec;
    logic [1:0]               fmod;
    logic [1:0]               dmod;
    logic [`FLASH_CHK_W-1:0]  syn;
    logic [`FLASH_LINE_W:0]   fix;
    logic                     pw_ok;
    ft     = decode(fetch_addr);
    dt     = decode(data_addr);
    da     = data_word ? {data_addr[`ADDR_W-1:1], 1'b0} : data_addr;
    gsec   = {data_addr[19:18], data_addr[17:12]};
    fmod   = fetch_addr[19:18];
    dmod   = data_addr[19:18];
    syn    = ecc_syndrome(flash_rdata, flash_rcheck);
    fix    = ecc_fix(flash_rdata, syn);
    pw_ok  = pw_word == pw_key[st_r.pw_idx*16 +: 16];
    st_nxt = st_r;

    // code side owns every fetch; other targets except trap cross over the system bus
    st_nxt.f_valid  = fetch_req;
    st_nxt.f_tgt    = ft;
    st_nxt.f_addr   = fold(ft, fetch_addr);
    st_nxt.f_trap   = fetch_req && (ft == TGT_TRAP ||
                      (ft == TGT_FLASH && is_ctrl_sector(fetch_addr)));
    st_nxt.f_sysbus = fetch_req && !is_code_mem(ft) && ft != TGT_TRAP;

    // data side owns every data transfer
    st_nxt.d_valid   = data_req;
    st_nxt.d_tgt     = dt;
    st_nxt.d_we      = data_we;
    st_nxt.d_be      = data_word ? 2'b11 : (data_addr[0] ? 2'b10 : 2'b01);
    st_nxt.d_addr    = fold(dt, da);
    st_nxt.d_wdata   = data_wdata;
    st_nxt.d_trap    = data_req && dt == TGT_TRAP;
    // independent of the fetch crossing, so both directions run together
    st_nxt.d_sysbus  = data_req && (is_code_mem(dt) || dt == TGT_EXT ||
                       dt == TGT_LBUS);
    st_nxt.d_ioorder = data_req && data_addr >= `EXTIO_BASE &&
                       data_addr <= `EXTIO_END;
    st_nxt.d_bitok   = data_req && (dt == TGT_SFR || dt == TGT_EXTENDED_FUNCTION_REGS ||
                       (dt == TGT_DUAL_PORT_RAM && data_addr[15:8] == `DUAL_PORT_RAM_BIT_PAGE));

    // write blocking
    st_nxt.d_wblock = 1'b0;
    if (data_req && data_we) begin
      if ((dt == TGT_PROGRAM_SRAM || dt == TGT_FLASH_TIMED_PROGRAM_RAM) &&
          {1'b0, data_addr[14:10]} < program_sram_wp_kbytes)
        st_nxt.d_wblock = 1'b1;
      if (dt == TGT_FLASH && (flash_sector_wp[gsec] || is_ctrl_sector(data_addr)))
        st_nxt.d_wblock = 1'b1;
    end
    st_nxt.d_rdeny = data_req && !data_we && dt == TGT_FLASH &&
                     flash_read_prot && st_r.pw_state == PW_LOCKED;

    // one 128-bit line read per module; distinct modules run in parallel
    st_nxt.fl_en        = '0;
    st_nxt.fl_from_data = '0;
    st_nxt.d_retry      = 1'b0;
    if (fetch_req && ft == TGT_FLASH && !st_nxt.f_trap)
      st_nxt.fl_en[fmod] = 1'b1;
    if (data_req && !data_we && dt == TGT_FLASH && !st_nxt.d_rdeny) begin
      if (st_nxt.fl_en[dmod]) begin
        st_nxt.d_retry = 1'b1;
      end else begin
        st_nxt.fl_en[dmod]        = 1'b1;
        st_nxt.fl_from_data[dmod] = 1'b1;
      end
    end

    // register bank: word n at base+2n, byte halves of the low eight words
    st_nxt.gpr_valid = gpr_req && !(gpr_byte && gpr_num[3]);
    if (gpr_byte)
      st_nxt.gpr_addr = gpr_base + {20'h00000, gpr_num[2:0], gpr_high};
    else
      st_nxt.gpr_addr = gpr_base + {19'h00000, gpr_num, 1'b0};

    // password sequence; completing it wins over a relock in the same cycle
    if (pw_relock)
      st_nxt.pw_state = PW_LOCKED;
    if (pw_valid) begin
      if (pw_ok && st_r.pw_idx == 2'(`PW_WORDS - 1)) begin
        st_nxt.pw_state = PW_OPEN;
        st_nxt.pw_idx   = 2'd0;
      end else if (pw_ok) begin
        st_nxt.pw_idx = st_r.pw_idx + 2'd1;
      end else begin
        st_nxt.pw_idx = 2'd0;
      end
    end

    // corrected read data, one stage after the flash returns it
    st_nxt.ecc_valid  = flash_rvalid;
    st_nxt.ecc_data   = fix[`FLASH_LINE_W-1:0];
    st_nxt.ecc_corr   = flash_rvalid && fix[`FLASH_LINE_W];
    st_nxt.ecc_uncorr = flash_rvalid && syn != '0 && !fix[`FLASH_LINE_W] &&
                        (syn & (syn - 8'h01)) != 8'h00;
  end

  // ************************************************************
  // state register
  // ************************************************************

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r          <= '0;
      st_r.f_tgt    <= TGT_NONE;
      st_r.d_tgt    <= TGT_NONE;
      st_r.pw_state <= PW_LOCKED;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************

  assign fetch_valid       = st_r.f_valid;
  assign fetch_target      = st_r.f_tgt;
  assign fetch_addr_out    = st_r.f_addr;
  assign fetch_via_sysbus  = st_r.f_sysbus;
  assign fetch_trap        = st_r.f_trap;
  assign acc_valid         = st_r.d_valid;
  assign acc_target        = st_r.d_tgt;
  assign acc_we            = st_r.d_we;
  assign acc_be            = st_r.d_be;
  assign acc_addr          = st_r.d_addr;
  assign acc_wdata         = st_r.d_wdata;
  assign acc_via_sysbus    = st_r.d_sysbus;
  assign acc_trap          = st_r.d_trap;
  assign acc_write_blocked = st_r.d_wblock;
  assign acc_read_denied   = st_r.d_rdeny;
  assign acc_io_ordered    = st_r.d_ioorder;
  assign acc_bit_ok        = st_r.d_bitok;
  assign acc_retry         = st_r.d_retry;
  assign flash_rd_en       = st_r.fl_en;
  assign flash_rd_for_data = st_r.fl_from_data;
  assign gpr_valid         = st_r.gpr_valid;
  assign gpr_addr          = st_r.gpr_addr;
  assign flash_unlocked    = st_r.pw_state == PW_OPEN;
  assign ecc_valid         = st_r.ecc_valid;
  assign ecc_data          = st_r.ecc_data;
  assign ecc_corrected     = st_r.ecc_corr;
  assign ecc_uncorrectable = st_r.ecc_uncorr;

endmodule : memory_map_decoder
`default_nettype wire

// ===== bench/cpu_port_model.sv
// cpu side model driving fetch and data requests
`timescale 1ns/1ps
`default_nettype none
module cpu_port_model (
  // cpu side request lines
  input  wire logic   clk,
  output logic        fetch_req, data_req, data_we, data_word,
  output logic [23:0] fetch_addr, data_addr,
  output logic [15:0] data_wdata
);
  initial {fetch_req, data_req, data_we, data_word, fetch_addr, data_addr, data_wdata} = '0;
  // one request cycle on each side, lines scrambled once released
  task automatic go(input logic f, input logic [23:0] fa, input logic d, we, wd,
                    input logic [23:0] da, input logic [15:0] w);
    @(negedge clk);
    fetch_req  = f;
    fetch_addr = fa;
    data_req   = d;
    data_we    = we;
    data_word  = wd;
    data_addr  = da;
    data_wdata = (da[23:9] == 15'h007f) ? 16'h0000 : w;
    @(negedge clk);
    {fetch_req, data_req} = 2'b00;
    {fetch_addr, data_addr, data_wdata} = ~{fetch_addr, data_addr, data_wdata};
  endtask : go
endmodule : cpu_port_model
`default_nettype wire

// ===== bench/memory_map_decoder_asserts.sv
// concurrent checks on the memory map decoder ports
`timescale 1ns/1ps
`default_nettype none
module memory_map_checks
  import memory_map_pkg::*;
(
  input wire logic        clk, rst_n, fetch_req, fetch_valid, fetch_trap, data_req, data_word,
  input wire logic        acc_io_ordered, acc_trap, pw_valid, pw_relock, flash_unlocked,
  input wire logic        gpr_req, gpr_byte, gpr_valid,
  input wire logic [23:0] fetch_addr, data_addr, gpr_base, gpr_addr,
  input wire logic [3:0]  gpr_num,
  input wire logic [1:0]  acc_be,
  input wire target_t     acc_target
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  fetch_answer_a: assert property (fetch_req |=> fetch_valid)
    else $error("fetch not answered");
  byte_lanes_a: assert property (data_req && !data_word |=>
    acc_be == ($past(data_addr[0]) ? 2'b10 : 2'b01)) else $error("byte lane wrong");
  io_order_a: assert property (data_req && data_addr inside {[24'h210000:24'h3fffff]}
    |=> acc_io_ordered) else $error("io access not ordered");
  data_sram_route_a: assert property (data_req && data_addr inside {[24'h00a000:24'h00dfff]}
    |=> acc_target == TGT_DATA_SRAM) else $error("data sram not selected");
  trap_top_a: assert property (data_req && data_addr inside {[24'hf00000:24'hfffeff]}
    |=> acc_trap && acc_target == TGT_TRAP) else $error("reserved top not trapped");
  ctrl_sector_a: assert property (
    fetch_req && fetch_addr[23:12] == 12'hc0f |=> fetch_trap) else $error("sector not trapped");
  relock_a: assert property (pw_relock && !pw_valid |=> !flash_unlocked)
    else $error("flash still unlocked");
  gpr_word_a: assert property (gpr_req && !gpr_byte |=> gpr_valid &&
    gpr_addr == $past(gpr_base) + {$past(gpr_num), 1'b0}) else $error("register address wrong");
endmodule : memory_map_checks
bind memory_map_decoder memory_map_checks u_memory_map_checks (.*);
`default_nettype wire

// ===== bench/test_memory_map_decoder.sv
// self-checking bench for the memory map decoder
`timescale 1ns/1ps
`default_nettype none
module test_memory_map_decoder;
  import memory_map_pkg::*;
  logic clk, rst_n, fetch_req, data_req, data_we, data_word, gpr_req, gpr_byte, gpr_high, we, wd;
  logic flash_read_prot, pw_valid, pw_relock, flash_rvalid, fetch_valid, fetch_via_sysbus;
  logic fetch_trap, acc_valid, acc_we, acc_via_sysbus, acc_trap, acc_write_blocked, acc_bit_ok;
  logic acc_read_denied, acc_io_ordered, acc_retry, gpr_valid, flash_unlocked, ecc_valid;
  logic ecc_corrected, ecc_uncorrectable;
  logic [23:0] fetch_addr, data_addr, gpr_base, fetch_addr_out, acc_addr, gpr_addr, fa, da;
  logic [15:0] data_wdata, pw_word, acc_wdata;
  logic [3:0] gpr_num, flash_rd_en, flash_rd_for_data, e1, e2;
  logic [5:0] program_sram_wp_kbytes;
  logic [255:0] flash_sector_wp;
  logic [63:0] pw_key;
  logic [127:0] flash_rdata, ecc_data, line;
  logic [7:0] flash_rcheck, s;
  logic [1:0] acc_be;
  target_t fetch_target, acc_target, ft, dt;
  logic [7:0] hbs [14] = '{8'h00, 8'h00, 8'h00, 8'h20, 8'h21, 8'h40, 8'hc0, 8'hc4, 8'hc8,
                           8'hcc, 8'hd0, 8'he0, 8'he8, 8'hf5};
  logic [23:0] corner [9] = '{24'hfffeff, 24'hffff00, 24'h00f5ff, 24'h00f600, 24'h20bfff,
                              24'h20c000, 24'h3fffff, 24'h400000, 24'h00fdfe};
  integer failures = 0, total_checks = 0, seed = 32'h003c, i, n;
  cpu_port_model u_cpu_port_model (.*);
  memory_map_decoder u_memory_map_decoder (.*);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [127:0] e, v);
    total_checks++;
    if (e !== v) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, v);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  function automatic target_t tgt(input logic [23:0] a);
    logic [15:0] l;
    l = a[15:0];
    if (a[23:16] == 8'h00) return l < 16'h8000 ? TGT_EXT : l < 16'ha000 ? TGT_STANDBY_RAM :
      l < 16'he000 ? TGT_DATA_SRAM : l < 16'hf000 ? TGT_EXTRA_PERIPH_REGS : l < 16'hf200 ? TGT_EXTENDED_FUNCTION_REGS :
      l < 16'hf600 ? TGT_EXT : l < 16'hfe00 ? TGT_DUAL_PORT_RAM : TGT_SFR;
    if (a[23:16] == 8'h20) return (l < 16'h6000 || l[15:14] == 2'b10) ? TGT_LBUS : TGT_EXT;
    return a < 24'hc00000 ? TGT_EXT : a < 24'hcd0000 ? TGT_FLASH : a < 24'he00000 ? TGT_EXT :
      a < 24'he80000 ? TGT_PROGRAM_SRAM : a < 24'hf00000 ? TGT_FLASH_TIMED_PROGRAM_RAM : a < 24'hffff00 ? TGT_TRAP : TGT_IMB;
  endfunction : tgt
  function automatic logic [23:0] fold(input logic [23:0] a);
    fold = a;
    if (tgt(a) inside {TGT_PROGRAM_SRAM, TGT_FLASH_TIMED_PROGRAM_RAM}) fold[18:15] = 4'h0;
  endfunction : fold
  function automatic logic [7:0] cbits(input logic [127:0] d);
    int p;
    p = 2;
    cbits = 8'h00;
    for (int b = 0; b < 128; b++) begin
      p++;
      while ((p & (p - 1)) == 0) p++;
      if (d[b]) cbits ^= p[7:0];
    end
  endfunction : cbits
  task automatic acc(input logic [23:0] a1, input logic w1, w2, input logic [23:0] a2);
    u_cpu_port_model.go(1'b1, a1, 1'b1, w1, w2, a2, 16'($random(seed)));
  endtask : acc
  task automatic pw(input logic [15:0] w);
    @(negedge clk);
    {pw_valid, pw_word} = {1'b1, w};
    @(negedge clk);
    {pw_valid, pw_word} = {1'b0, ~w};
  endtask : pw
  initial begin
    repeat (50000) @(posedge clk);
    failures++;
    give_verdict;
  end
  initial begin
    {rst_n, gpr_req, gpr_byte, gpr_high, gpr_base, gpr_num, program_sram_wp_kbytes} = '0;
    {flash_sector_wp, flash_read_prot, pw_valid, pw_word, pw_key, pw_relock} = '0;
    {flash_rvalid, flash_rdata, flash_rcheck} = '0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    for (i = 0; i < 300; i++) begin
      da = i < 9 ? corner[i] : {hbs[{$random(seed)} % 14], 16'($random(seed))};
      fa = i == 1 ? 24'hc0f004 : {hbs[{$random(seed)} % 14], 16'($random(seed))};
      {we, wd} = 2'($random(seed));
      dt = tgt(da);
      ft = tgt(fa);
      s[3] = ft == TGT_FLASH && fa[23:12] != 12'hc0f;
      s[2] = s[3] && dt == TGT_FLASH && !we && fa[19:18] == da[19:18];
      e1 = s[3] ? 4'h1 << fa[19:18] : 4'h0;
      e2 = dt == TGT_FLASH && !we && !s[2] ? 4'h1 << da[19:18] : 4'h0;
      acc(fa, we, wd, da);
      chk("valid", {fetch_valid, acc_valid}, 2'b11);
      chk("target", dt, acc_target);
      chk("fetch_target", ft, fetch_target);
      chk("be", wd ? 2'b11 : da[0] ? 2'b10 : 2'b01, acc_be);
      chk("addr", fold(wd ? {da[23:1], 1'b0} : da), acc_addr);
      chk("fetch_addr", fold(fa), fetch_addr_out);
      chk("fetch_trap", ft == TGT_TRAP || (ft == TGT_FLASH && !s[3]), fetch_trap);
      chk("fetch_sysbus", !(ft inside {TGT_FLASH, TGT_PROGRAM_SRAM, TGT_FLASH_TIMED_PROGRAM_RAM, TGT_TRAP}),
          fetch_via_sysbus);
      chk("we", we, acc_we);
      chk("io", da inside {[24'h210000:24'h3fffff]}, acc_io_ordered);
      chk("sysbus", dt inside {TGT_FLASH, TGT_PROGRAM_SRAM, TGT_FLASH_TIMED_PROGRAM_RAM, TGT_EXT, TGT_LBUS},
          acc_via_sysbus);
      chk("trap", dt == TGT_TRAP, acc_trap);
      chk("wblock", we && da[23:12] == 12'hc0f, acc_write_blocked);
      chk("retry", s[2], acc_retry);
      chk("rd_en", {e1 | e2, e2}, {flash_rd_en, flash_rd_for_data});
      if (dt == TGT_DUAL_PORT_RAM) chk("bit_ok", da[15:8] == 8'hfd, acc_bit_ok);
    end
    $display("map test done");
    n = 1 + {$random(seed)} % 31;
    program_sram_wp_kbytes = 6'(n);
    acc(24'h0, 1'b1, 1'b1, 24'he00000 + 24'(n * 1024 - 2));
    chk("wp_in", 1'b1, acc_write_blocked);
    acc(24'h0, 1'b1, 1'b1, 24'he08000 + 24'(n * 1024));
    chk("wp_out", 1'b0, acc_write_blocked);
    s = 8'({$random(seed)} % 204);
    flash_sector_wp[s] = 1'b1;
    acc(24'h0, 1'b1, 1'b1, {4'hc, s, 12'h000});
    chk("sector_wp", 1'b1, acc_write_blocked);
    flash_sector_wp = '0;
    acc(24'h0, 1'b1, 1'b1, {4'hc, s, 12'h000});
    chk("sector_free", s == 8'h0f, acc_write_blocked);
    $display("protect test done");
    flash_read_prot = 1'b1;
    pw_key = {$random(seed), $random(seed)};
    acc(24'h0, 1'b0, 1'b1, 24'hc40000);
    chk("denied", 1'b1, acc_read_denied);
    pw(pw_key[15:0]);
    pw(~pw_key[15:0]);
    for (i = 0; i < 4; i++) begin
      pw(pw_key[16 * i +: 16]);
      @(negedge clk);
      chk("unlocked", i == 3, flash_unlocked);
    end
    acc(24'h0, 1'b0, 1'b1, 24'hc40000);
    chk("allowed", 1'b0, acc_read_denied);
    pw_relock = 1'b1;
    @(negedge clk);
    pw_relock = 1'b0;
    @(negedge clk);
    chk("relocked", 1'b0, flash_unlocked);
    $display("password test done");
    for (i = 0; i < 3; i++) begin
      line = {4{$random(seed)}};
      n = {$random(seed)} % 128;
      flash_rvalid = 1'b1;
      flash_rdata = i != 0 ? line : line ^ (128'h1 << n);
      flash_rcheck = cbits(line) ^ (i == 2 ? 8'hf0 : 8'(i));
      @(negedge clk);
      flash_rvalid = 1'b0;
      chk("ecc", {line, 1'b1, i == 0, i == 2},
          {ecc_data, ecc_valid, ecc_corrected, ecc_uncorrectable});
    end
    for (i = 0; i < 24; i++) begin
      gpr_req = 1'b1;
      {gpr_base, gpr_num, gpr_byte, gpr_high} = {24'h00f600 + 24'(2 * i), 4'(3 * i), i > 15, i[0]};
      @(negedge clk);
      gpr_req = 1'b0;
      chk("gpr_valid", !(gpr_byte && gpr_num[3]), gpr_valid);
      chk("gpr", gpr_base + 24'(gpr_byte ? 2 * gpr_num[2:0] + gpr_high : 2 * gpr_num),
          gpr_addr);
    end
    $display("ecc and register test done");
    give_verdict;
  end
endmodule : test_memory_map_decoder
`default_nettype wire
